/* File: logic/msns_mac.sv */
`timescale 1ns/1ns
`include "msns_regs.svh"
// Functional notes
// - Square: signed Wm*Wm, sign-extend 32 to 40 bits, into chosen accumulator.
// - Negated multiply: signed product sign-extended to 40 bits, then negated, into accumulator.
// - Multiply-subtract: accumulator minus sign-extended signed product.
// - Post-modify pointer steps only by -6, -4, -2, 2, 4 or 6 bytes.
// - Prefetch reads at old pointer address, then pointer is modified.
// - Register-offset prefetch reads pointer plus offset, modifies neither.
// - Multiply-subtract may write back the other accumulator.
// - Squaring may also prefetch operands for a following operation.
module msns_mac #(
  parameter int ACC_W = `MSNS_ACC_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic op_valid,
  input wire msns_pkg::msns_op_type op,
  input wire logic [15:0] core_control_register,
  input wire logic acc_sel,
  input wire logic [15:0] mul_a,
  input wire logic [15:0] mul_b,
  input wire msns_pkg::msns_pf_type pf_x_mode,
  input wire logic [2:0] pf_x_step,
  input wire logic [15:0] first_prefetch_pointer,
  input wire logic [15:0] pf_x_offs,
  input wire msns_pkg::msns_pf_type pf_y_mode,
  input wire logic [2:0] pf_y_step,
  input wire logic [15:0] second_prefetch_pointer,
  input wire logic [15:0] pf_y_offs,
  input wire logic [1:0] wb_mode,
  output logic [15:0] pf_x_addr,
  output logic [15:0] pf_y_addr,
  output logic pf_x_rd,
  output logic pf_y_rd,
  output logic [15:0] pf_x_ptr_new,
  output logic [15:0] pf_y_ptr_new,
  output logic pf_x_ptr_we,
  output logic pf_y_ptr_we,
  output logic [15:0] accumulator_writeback,
  output logic wb_reg_we,
  output logic wb_mem_we,
  output logic [ACC_W-1:0] accumulator_a,
  output logic [ACC_W-1:0] accumulator_b,
  output logic acc_a_overflow_flag,
  output logic acc_b_overflow_flag,
  output logic combined_overflow_flag,
  output logic acc_a_saturation_flag,
  output logic acc_b_saturation_flag,
  output logic combined_saturation_flag
);
  import msns_pkg::*;
  logic [ACC_W-1:0] acc_a_r;
  logic [ACC_W-1:0] acc_b_r;
  logic [ACC_W-1:0] acc_nxt;
  logic [ACC_W-1:0] acc_cur;
  logic [ACC_W-1:0] prod_ext;
  logic signed [31:0] prod_raw;
  logic [31:0] prod;
  logic [15:0] src_b;
  logic ov_a_r;
  logic ov_b_r;
  logic sat_a_r;
  logic sat_b_r;
  logic ov_nxt;
  logic sat_nxt;
  logic [15:0] wb_r;
  logic wb_reg_r;
  logic wb_mem_r;
  logic go;

  assign go = op_valid && (op != MSNS_OP_NONE);

  // Overflow into guard bits: bits 39..31 not all equal
  function automatic logic guard_ovf(input logic [ACC_W-1:0] v);
    guard_ovf = !((&v[ACC_W-1:31]) || !(|v[ACC_W-1:31]));
  endfunction : guard_ovf

  // Catastrophic overflow: sign of 40-bit result inconsistent with operands
  function automatic logic sign_ovf(input logic [ACC_W-1:0] a, input logic [ACC_W-1:0] b,
                                    input logic [ACC_W-1:0] r);
    sign_ovf = (a[ACC_W-1] != b[ACC_W-1]) && (r[ACC_W-1] != a[ACC_W-1]);
  endfunction : sign_ovf

  assign src_b = (op == MSNS_OP_SQUARE) ? mul_a : mul_b;
  assign prod_raw = $signed(mul_a) * $signed(src_b);
  // Fractional mode shifts left one; integer mode keeps the raw product
  assign prod = core_control_register[`MSNS_CTRL_INT_BIT] ? prod_raw :
                {prod_raw[30:0], 1'b0};
  assign prod_ext = {{(ACC_W-32){prod[31]}}, prod};
  assign acc_cur = acc_sel ? acc_b_r : acc_a_r;

  always_comb begin
    acc_nxt = acc_cur;
    ov_nxt = 1'b0;
    sat_nxt = 1'b0;
    unique case (op)
      MSNS_OP_SQUARE: begin
        acc_nxt = prod_ext;
        ov_nxt = guard_ovf(acc_nxt);
      end
      MSNS_OP_NEG: begin
        acc_nxt = ACC_W'(0) - prod_ext;
        ov_nxt = guard_ovf(acc_nxt);
      end
      MSNS_OP_SUB: begin
        acc_nxt = acc_cur - prod_ext;
        ov_nxt = guard_ovf(acc_nxt);
        sat_nxt = sign_ovf(acc_cur, prod_ext, acc_nxt);
      end
      default: begin
      end
    endcase
  end

  // Accumulators: one-cycle update
  always_ff @(posedge clk) begin
    if (rst) begin
      acc_a_r <= '0;
      acc_b_r <= '0;
    end else if (go) begin
      if (acc_sel) begin
        acc_b_r <= acc_nxt;
      end else begin
        acc_a_r <= acc_nxt;
      end
    end
  end

  // Flags of the target accumulator only; saturation sticky like a status bit
  always_ff @(posedge clk) begin
    if (rst) begin
      ov_a_r <= 1'b0;
      ov_b_r <= 1'b0;
      sat_a_r <= 1'b0;
      sat_b_r <= 1'b0;
    end else if (go) begin
      if (acc_sel) begin
        ov_b_r <= ov_nxt;
        sat_b_r <= sat_b_r | sat_nxt;
      end else begin
        ov_a_r <= ov_nxt;
        sat_a_r <= sat_a_r | sat_nxt;
      end
    end
  end

  // Write-back of the other accumulator's high word, multiply-subtract only
  always_ff @(posedge clk) begin
    if (rst) begin
      wb_r <= '0;
      wb_reg_r <= 1'b0;
      wb_mem_r <= 1'b0;
    end else begin
      wb_reg_r <= go && (op == MSNS_OP_SUB) && (wb_mode == `MSNS_WB_REG);
      wb_mem_r <= go && (op == MSNS_OP_SUB) && (wb_mode == `MSNS_WB_MEM);
      if (go && (op == MSNS_OP_SUB) && (wb_mode != `MSNS_WB_NONE)) begin
        wb_r <= acc_sel ? acc_a_r[31:16] : acc_b_r[31:16];
      end
    end
  end

  msns_prefetch u_pf_x (
    .ptr(first_prefetch_pointer),
    .offs(pf_x_offs),
    .mode(go ? pf_x_mode : MSNS_PF_NONE),
    .step_sel(pf_x_step),
    .addr(pf_x_addr),
    .ptr_new(pf_x_ptr_new),
    .ptr_we(pf_x_ptr_we)
  );

  msns_prefetch u_pf_y (
    .ptr(second_prefetch_pointer),
    .offs(pf_y_offs),
    .mode(go ? pf_y_mode : MSNS_PF_NONE),
    .step_sel(pf_y_step),
    .addr(pf_y_addr),
    .ptr_new(pf_y_ptr_new),
    .ptr_we(pf_y_ptr_we)
  );

  // Prefetch reads are combinational so the fetch lands in the same cycle
  assign pf_x_rd = go && (pf_x_mode != MSNS_PF_NONE);
  assign pf_y_rd = go && (pf_y_mode != MSNS_PF_NONE);

  assign accumulator_a = acc_a_r;
  assign accumulator_b = acc_b_r;
  assign acc_a_overflow_flag = ov_a_r;
  assign acc_b_overflow_flag = ov_b_r;
  assign combined_overflow_flag = ov_a_r | ov_b_r;
  assign acc_a_saturation_flag = sat_a_r;
  assign acc_b_saturation_flag = sat_b_r;
  assign combined_saturation_flag = sat_a_r | sat_b_r;
  assign accumulator_writeback = wb_r;
  assign wb_reg_we = wb_reg_r;
  assign wb_mem_we = wb_mem_r;

  chk_square_result: assert property (@(posedge clk) disable iff (rst)
    go && op == MSNS_OP_SQUARE && !acc_sel |=> acc_a_r == $past(prod_ext))
    else $error("square result wrong");
  chk_negate_result: assert property (@(posedge clk) disable iff (rst)
    go && op == MSNS_OP_NEG && acc_sel |=> acc_b_r == ACC_W'(0) - $past(prod_ext))
    else $error("negated result wrong");
  chk_sub_result: assert property (@(posedge clk) disable iff (rst)
    go && op == MSNS_OP_SUB && !acc_sel |=> acc_a_r == $past(acc_a_r) - $past(prod_ext))
    else $error("subtract result wrong");
  chk_int_mode: assert property (@(posedge clk) disable iff (rst)
    go && op == MSNS_OP_SQUARE && !acc_sel && core_control_register[`MSNS_CTRL_INT_BIT] |=>
    acc_a_r == $past({{(ACC_W-16){mul_a[15]}}, mul_a} * {{(ACC_W-16){mul_a[15]}}, mul_a}))
    else $error("integer mode product wrong");
  chk_comb_flags: assert property (@(posedge clk) disable iff (rst)
    combined_overflow_flag == (acc_a_overflow_flag | acc_b_overflow_flag) &&
    combined_saturation_flag == (acc_a_saturation_flag | acc_b_saturation_flag))
    else $error("flag combination wrong");
  chk_sub_ovf: assert property (@(posedge clk) disable iff (rst)
    go && op == MSNS_OP_SUB && !acc_sel |=>
    acc_a_overflow_flag == (accumulator_a[ACC_W-1:31] != '0 && accumulator_a[ACC_W-1:31] != '1))
    else $error("subtract overflow flag wrong");
  // No clear port, so only reset may drop it
  chk_sat_sticky: assert property (@(posedge clk) disable iff (rst)
    acc_a_saturation_flag |=> acc_a_saturation_flag)
    else $error("saturation flag not sticky");
  chk_step_range: assert property (@(posedge clk) disable iff (rst)
    pf_x_ptr_we |-> (pf_x_ptr_new - first_prefetch_pointer) inside
    {16'hFFFA, 16'hFFFC, 16'hFFFE, 16'h0002, 16'h0004, 16'h0006})
    else $error("pointer step out of range");
  chk_post_addr: assert property (@(posedge clk) disable iff (rst)
    pf_x_rd && pf_x_mode == MSNS_PF_POST |-> pf_x_addr == first_prefetch_pointer)
    else $error("post-modify address not old pointer");
  chk_offs_addr: assert property (@(posedge clk) disable iff (rst)
    pf_y_rd && pf_y_mode == MSNS_PF_OFFS |->
    pf_y_addr == second_prefetch_pointer + pf_y_offs && !pf_y_ptr_we)
    else $error("offset prefetch wrong");
  chk_wb_source: assert property (@(posedge clk) disable iff (rst)
    go && op == MSNS_OP_SUB && wb_mode == `MSNS_WB_MEM && !acc_sel |=>
    wb_mem_we && accumulator_writeback == $past(acc_b_r[31:16]))
    else $error("write-back wrong");
  chk_one_cycle: assert property (@(posedge clk) disable iff (rst)
    go && !acc_sel |=> acc_a_r == $past(acc_nxt))
    else $error("operation not done in one cycle");
  cov_square_pf: cover property (@(posedge clk) go && op == MSNS_OP_SQUARE && pf_x_rd);
  cov_neg: cover property (@(posedge clk) go && op == MSNS_OP_NEG);
  cov_sub_wb: cover property (@(posedge clk) go && op == MSNS_OP_SUB && wb_mode != 2'h0);
  cov_sat: cover property (@(posedge clk) sat_nxt && go);
endmodule : msns_mac

/* File: shared/msns_regs.svh */
`ifndef MSNS_REGS_SVH
`define MSNS_REGS_SVH
`define MSNS_CTRL_INT_BIT 0
`define MSNS_ACC_W 40
`define MSNS_WORD_W 16
`define MSNS_PROD_W 32
`define MSNS_WB_NONE 2'h0
`define MSNS_WB_REG 2'h1
`define MSNS_WB_MEM 2'h2
`endif

/* File: shared/msns_pkg.sv */
package msns_pkg;
  typedef enum logic [1:0] {
    MSNS_OP_NONE = 2'h0,
    MSNS_OP_SQUARE = 2'h1,
    MSNS_OP_NEG = 2'h2,
    MSNS_OP_SUB = 2'h3
  } msns_op_type;
  typedef enum logic [1:0] {
    MSNS_PF_NONE = 2'h0,
    MSNS_PF_POST = 2'h1,
    MSNS_PF_OFFS = 2'h2
  } msns_pf_type;
endpackage : msns_pkg

/* File: logic/msns_prefetch.sv */
`timescale 1ns/1ns
`include "msns_regs.svh"
module msns_prefetch (
  input wire logic [15:0] ptr,
  input wire logic [15:0] offs,
  input wire msns_pkg::msns_pf_type mode,
  input wire logic [2:0] step_sel,
  output logic [15:0] addr,
  output logic [15:0] ptr_new,
  output logic ptr_we
);
  import msns_pkg::*;
  function automatic logic [15:0] step_amount(input logic [2:0] s);
    unique case (s)
      3'h0: step_amount = 16'hFFFA;
      3'h1: step_amount = 16'hFFFC;
      3'h2: step_amount = 16'hFFFE;
      3'h3: step_amount = 16'h0002;
      3'h4: step_amount = 16'h0004;
      default: step_amount = 16'h0006;
    endcase
  endfunction : step_amount
  always_comb begin
    addr = ptr;
    ptr_new = ptr;
    ptr_we = 1'b0;
    unique case (mode)
      MSNS_PF_POST: begin
        // Address is the old pointer; step applied after
        ptr_new = ptr + step_amount(step_sel);
        ptr_we = 1'b1;
      end
      MSNS_PF_OFFS: begin
        addr = ptr + offs;
      end
      default: begin
      end
    endcase
  end
endmodule : msns_prefetch

/* File: test/msns_regfile.sv */
`timescale 1ns/1ns
module msns_regfile (
  input wire logic clk,
  input wire logic rst,
  input wire logic ld,
  input wire logic [15:0] ld_x,
  input wire logic [15:0] ld_y,
  input wire logic x_we,
  input wire logic [15:0] x_new,
  input wire logic y_we,
  input wire logic [15:0] y_new,
  output logic [15:0] x_ptr_r,
  output logic [15:0] y_ptr_r
);
  // Pointer update lands after the read cycle, never inside it
  always_ff @(posedge clk) begin
    if (rst) begin
      x_ptr_r <= 16'h0000;
      y_ptr_r <= 16'h0000;
    end else if (ld) begin
      x_ptr_r <= ld_x;
      y_ptr_r <= ld_y;
    end else begin
      if (x_we) x_ptr_r <= x_new;
      if (y_we) y_ptr_r <= y_new;
    end
  end
endmodule : msns_regfile

/* File: test/testbench.sv */
`timescale 1ns/1ns
module testbench;
  import msns_pkg::*;
  logic clk, rst, op_valid, acc_sel, ld, pf_x_rd, pf_y_rd, pf_x_ptr_we, pf_y_ptr_we;
  msns_op_type op;
  msns_pf_type pf_x_mode, pf_y_mode;
  logic [15:0] core_control_register, mul_a, mul_b, pf_x_offs, pf_y_offs, ld_x, ld_y, ex;
  logic [15:0] first_prefetch_pointer, second_prefetch_pointer, pf_x_addr, pf_y_addr;
  logic [15:0] pf_x_ptr_new, pf_y_ptr_new, accumulator_writeback;
  logic [2:0] pf_x_step, pf_y_step;
  logic [1:0] wb_mode;
  logic wb_reg_we, wb_mem_we, acc_a_overflow_flag, acc_b_overflow_flag, combined_overflow_flag;
  logic acc_a_saturation_flag, acc_b_saturation_flag, combined_saturation_flag;
  logic [39:0] accumulator_a, accumulator_b;
  int error_cnt = 0;
  int n_compared = 0;
  int steps [6] = '{-6, -4, -2, 2, 4, 6};
  msns_mac i_dut (.clk, .rst, .op_valid, .op, .core_control_register, .acc_sel, .mul_a,
    .mul_b, .pf_x_mode, .pf_x_step, .first_prefetch_pointer, .pf_x_offs, .pf_y_mode,
    .pf_y_step, .second_prefetch_pointer, .pf_y_offs, .wb_mode, .pf_x_addr, .pf_y_addr,
    .pf_x_rd, .pf_y_rd, .pf_x_ptr_new, .pf_y_ptr_new, .pf_x_ptr_we, .pf_y_ptr_we,
    .accumulator_writeback, .wb_reg_we, .wb_mem_we, .accumulator_a, .accumulator_b,
    .acc_a_overflow_flag, .acc_b_overflow_flag, .combined_overflow_flag,
    .acc_a_saturation_flag, .acc_b_saturation_flag, .combined_saturation_flag);
  msns_regfile i_regs (.clk, .rst, .ld, .ld_x, .ld_y, .x_we(pf_x_ptr_we),
    .x_new(pf_x_ptr_new), .y_we(pf_y_ptr_we), .y_new(pf_y_ptr_new),
    .x_ptr_r(first_prefetch_pointer), .y_ptr_r(second_prefetch_pointer));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick
  task automatic ldp(input logic [15:0] x, input logic [15:0] y);
    op_valid = 1'b0;
    ld = 1'b1;
    ld_x = x;
    ld_y = y;
    tick();
    ld = 1'b0;
  endtask : ldp
  // Drives one instruction; returns with comb outputs settled, before its edge
  task automatic drive(input msns_op_type o, input logic s, input logic [15:0] a,
    input logic [15:0] b, input logic intg);
    op_valid = 1'b1;
    op = o;
    acc_sel = s;
    mul_a = a;
    mul_b = b;
    core_control_register = {15'h0000, intg};
    #1;
  endtask : drive
  task automatic summarize();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize
  initial begin
    #20000;
    error_cnt++;
    summarize();
  end
  initial begin
    {rst, op_valid, acc_sel, ld, mul_a, mul_b, pf_x_offs, pf_y_offs} = '0;
    {core_control_register, ld_x, ld_y, pf_x_step, pf_y_step, wb_mode} = '0;
    op = MSNS_OP_NONE;
    pf_x_mode = MSNS_PF_POST;
    pf_y_mode = MSNS_PF_NONE;
    rst = 1'b1;
    repeat (20) @(posedge clk);
    #1;
    rst = 1'b0;
    chk(accumulator_a, 40'h00_0000_0000);
    ldp(16'h0800, 16'h0000);
    ex = 16'h0800;
    for (int s = 0; s < 6; s++) begin
      pf_x_step = 3'(s);
      drive(MSNS_OP_SQUARE, 1'b0, 16'h0000, 16'h0000, 1'b1);
      chk(pf_x_addr, ex);
      ex = ex + 16'(steps[s]);
      chk(pf_x_ptr_new, ex);
      tick();
      chk(first_prefetch_pointer, ex);
    end
    ldp(16'h0900, 16'h1B00);
    pf_x_step = 3'h3;
    drive(MSNS_OP_SQUARE, 1'b0, 16'h6500, 16'h0000, 1'b0);
    chk(pf_x_rd, 1'b1);
    tick();
    chk(accumulator_a, 40'h00_4FB2_0000);
    chk(first_prefetch_pointer, 16'h0902);
    ldp(16'h1700, 16'h1B00);
    pf_x_mode = MSNS_PF_OFFS;
    pf_x_offs = 16'hFF00;
    pf_y_mode = MSNS_PF_POST;
    pf_y_step = 3'h3;
    drive(MSNS_OP_SQUARE, 1'b1, 16'hE228, 16'h0000, 1'b0);
    chk(pf_x_addr, 16'h1600);
    chk(pf_x_ptr_we, 1'b0);
    chk(pf_y_ptr_new, 16'h1B02);
    tick();
    chk(accumulator_b, 40'h00_06F5_4C80);
    pf_x_mode = MSNS_PF_NONE;
    pf_y_mode = MSNS_PF_NONE;
    drive(MSNS_OP_NEG, 1'b0, 16'h3023, 16'h1290, 1'b1);
    tick();
    chk(accumulator_a, 40'hFF_FC82_7650);
    drive(MSNS_OP_NEG, 1'b0, 16'h3023, 16'h1290, 1'b0);
    tick();
    chk(accumulator_a, 40'hFF_F904_ECA0);
    drive(MSNS_OP_SQUARE, 1'b1, 16'h4000, 16'h0000, 1'b1);
    tick();
    drive(MSNS_OP_NEG, 1'b0, 16'h8000, 16'h0ACF, 1'b1);
    tick();
    chk(accumulator_b, 40'h00_1000_0000);
    chk(accumulator_a, 40'h00_0567_8000);
    ldp(16'h0C00, 16'h1C00);
    pf_x_mode = MSNS_PF_POST;
    pf_x_step = 3'h1;
    pf_y_mode = MSNS_PF_POST;
    pf_y_step = 3'h1;
    drive(MSNS_OP_SUB, 1'b0, 16'h9051, 16'h7230, 1'b1);
    chk(pf_y_ptr_new, 16'h1BFC);
    tick();
    chk(accumulator_a, 40'h00_3738_5ED0);
    chk(second_prefetch_pointer, 16'h1BFC);
    ldp(16'h0000, 16'h1800);
    pf_x_mode = MSNS_PF_NONE;
    pf_y_mode = MSNS_PF_OFFS;
    pf_y_offs = 16'h0800;
    wb_mode = 2'h1;
    drive(MSNS_OP_SUB, 1'b1, 16'h0500, 16'h2000, 1'b0);
    chk(pf_y_addr, 16'h2000);
    chk({pf_x_rd, pf_y_rd}, 2'h1);
    chk(pf_y_ptr_we, 1'b0);
    tick();
    chk(accumulator_b, 40'h00_0EC0_0000);
    chk({wb_reg_we, accumulator_writeback}, {1'b1, 16'h3738});
    pf_y_mode = MSNS_PF_NONE;
    wb_mode = 2'h0;
    drive(MSNS_OP_SUB, 1'b0, 16'h8000, 16'h7FFF, 1'b0);
    tick();
    chk(accumulator_a, 40'h00_B737_5ED0);
    chk({acc_a_overflow_flag, acc_b_overflow_flag, combined_overflow_flag}, 3'h5);
    chk({acc_a_saturation_flag, combined_saturation_flag}, 2'h0);
    wb_mode = 2'h2;
    drive(MSNS_OP_SQUARE, 1'b0, 16'h0002, 16'h0000, 1'b1);
    tick();
    chk({wb_mem_we, accumulator_a}, {1'b0, 40'h00_0000_0004});
    op_valid = 1'b0;
    op = MSNS_OP_SUB;
    tick();
    chk(accumulator_a, 40'h00_0000_0004);
    // Fractional -1 * -1 gives a negative product, so each subtract adds 2^31
    drive(MSNS_OP_SUB, 1'b0, 16'h8000, 16'h8000, 1'b0);
    tick();
    chk({wb_mem_we, wb_reg_we, accumulator_writeback}, {2'h2, 16'h0EC0});
    wb_mode = 2'h0;
    repeat (254) begin
      drive(MSNS_OP_SUB, 1'b0, 16'h8000, 16'h8000, 1'b0);
      tick();
    end
    chk(accumulator_a, 40'h7F_8000_0004);
    chk(combined_saturation_flag, 1'b0);
    drive(MSNS_OP_SUB, 1'b0, 16'h8000, 16'h8000, 1'b0);
    tick();
    chk(accumulator_a, 40'h80_0000_0004);
    chk({acc_a_saturation_flag, acc_b_saturation_flag, combined_saturation_flag}, 3'h5);
    drive(MSNS_OP_SQUARE, 1'b0, 16'h0000, 16'h0000, 1'b1);
    tick();
    chk({acc_a_overflow_flag, acc_a_saturation_flag}, 2'h1);
    summarize();
  end
endmodule : testbench
